// [spfc_pkg.sv]
// Purpose: Shared constants for the STN panel format control block
// Assumes: Host I/O ports are 16-bit addresses, data is 8 bits wide
// Notes:   Clock is the 40 MHz display clock
package spfc_pkg;

  // **********************************************************************
  // I/O port map
  // **********************************************************************
  localparam logic [15:0] SPFC_MONO_INDEX_PORT  = 16'h03B4;
  localparam logic [15:0] SPFC_MONO_DATA_PORT   = 16'h03B5;
  localparam logic [15:0] SPFC_COLOR_INDEX_PORT = 16'h03D4;
  localparam logic [15:0] SPFC_COLOR_DATA_PORT  = 16'h03D5;

  // **********************************************************************
  // Register index, reset and layout
  // **********************************************************************
  localparam logic [7:0] SPFC_FORMAT_INDEX = 8'h08;
  localparam logic [7:0] SPFC_FORMAT_RESET = 8'h00;
  localparam logic [7:0] SPFC_INDEX_RESET  = 8'h00;
  localparam logic [7:0] SPFC_FORMAT_WMASK = 8'hBF;
  localparam logic [7:0] SPFC_READ_IDLE    = 8'h00;

  localparam int SPFC_BIT_ALT_GRAY   = 7;
  localparam int SPFC_BIT_SINGLE_SCN = 5;
  localparam int SPFC_BIT_TEXT_ENH   = 4;
  localparam int SPFC_BIT_SHORT_LP   = 3;
  localparam int SPFC_BIT_DUAL_SCLK  = 1;
  localparam int SPFC_BIT_DATA_8BIT  = 0;

  // Panel type field value that lets the scan selection act
  localparam logic [1:0] SPFC_PANEL_TYPE_MONO = 2'h0;

  // **********************************************************************
  // Timing
  // **********************************************************************
  localparam int SPFC_CLK_PERIOD_PS = 25000;
  localparam int SPFC_SHORT_LP_PS   = 120000;
  // Least time: round up to whole cycles
  localparam int SPFC_SHORT_LP_CYC  =
    (SPFC_SHORT_LP_PS + SPFC_CLK_PERIOD_PS - 1) / SPFC_CLK_PERIOD_PS;
  localparam int SPFC_LP_CNT_W      = 4;

  // **********************************************************************
  // Line clock pin source
  // **********************************************************************
  typedef enum logic [1:0] {
    SPFC_LC_TIMED = 2'b00,
    SPFC_LC_SHORT = 2'b01,
    SPFC_LC_HSYNC = 2'b10
  } spfc_lc_src_t;

endpackage : spfc_pkg

// [spfc_pulse_gen.sv]
// Purpose: Fixed-width short line pulse generator
// Assumes: line_start_i is a one-cycle pulse per scan line
// Notes:   A start during a running pulse restarts the count
`timescale 1ns/100ps
module spfc_pulse_gen #(
  parameter int CNT_W = spfc_pkg::SPFC_LP_CNT_W,
  parameter int WIDTH = spfc_pkg::SPFC_SHORT_LP_CYC
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Line timing
  input  wire logic line_start_i,
  output logic      pulse_o
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  assign next_count = line_start_i    ? CNT_W'(WIDTH) :
                      (count != '0)   ? count - 1'b1  : count;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count   <= '0;
      pulse_o <= 1'b0;
    end else begin
      count   <= next_count;
      pulse_o <= (next_count != '0);
    end
  end

endmodule : spfc_pulse_gen

// [spfc_top.sv]
// Purpose: STN panel format register and panel format controls
// Assumes: Host I/O strobes are one cycle, synchronous to mclk_i
// Notes:   Other extension registers live elsewhere and feed inputs here
//
// Function
// RULE_01: Format register reachable only while unlocked
// RULE_02: Port address 3B5 mono, 3D5 colour
// RULE_03: Bit 7 selects alternate grayscale
// RULE_04: Bit 5 selects single or dual scan
// RULE_05: Scan select acts only for panel type 00
// RULE_06: Bit 4 enables foreground text enhancement
// RULE_07: Bit 3 with STN line clock: short pulse
// RULE_08: Bit 3 clear: pulse from timing registers
// RULE_09: Bit 1 selects dual shift clocks
// RULE_10: Dual-clock 8-bit panels need only bit 1
// RULE_11: Bit 0 selects 8-bit over 16-bit data
// RULE_12: Software sets bit 0 only for 8-bit single-clock
// RULE_13: Line clock select one routes horizontal sync
// RULE_14: Reserved bit 6 reads zero, ignores writes
`timescale 1ns/100ps
module spfc_top (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // Host I/O port
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  output logic             io_rdata_valid_o,
  // Settings held in neighbouring registers
  input  wire logic        color_mode_i,
  input  wire logic        extension_unlock_i,
  input  wire logic [1:0]  panel_type_i,
  input  wire logic        tft_line_clk_sel_i,
  // Line timing sources
  input  wire logic        line_start_i,
  input  wire logic        timed_line_pulse_i,
  input  wire logic        hsync_i,
  // Panel format controls
  output logic             alt_gray_o,
  output logic             mono_single_scan_o,
  output logic             text_enh_o,
  output logic             dual_shift_clk_o,
  output logic             data_8bit_o,
  output logic             panel_line_clock_o
);

  // **********************************************************************
  // Reset release
  // **********************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // **********************************************************************
  // Port decode
  // **********************************************************************
  function automatic logic port_hit(input logic [15:0] addr,
                                    input logic        color,
                                    input logic        data_port);
    logic [15:0] mono_p;
    logic [15:0] color_p;
    mono_p  = data_port ? spfc_pkg::SPFC_MONO_DATA_PORT
                        : spfc_pkg::SPFC_MONO_INDEX_PORT;
    color_p = data_port ? spfc_pkg::SPFC_COLOR_DATA_PORT
                        : spfc_pkg::SPFC_COLOR_INDEX_PORT;
    port_hit = (addr == (color ? color_p : mono_p));
  endfunction : port_hit

  logic [7:0] index;
  logic [7:0] format;

  wire index_hit;
  wire data_hit;
  wire fmt_sel;
  wire fmt_open;
  wire fmt_wr;
  wire fmt_rd;
  wire idx_wr;
  wire idx_rd;

  // RULE_02: mode picks port
  assign index_hit = port_hit(io_addr_i, color_mode_i, 1'b0);
  assign data_hit  = port_hit(io_addr_i, color_mode_i, 1'b1);
  assign fmt_sel   = (index == spfc_pkg::SPFC_FORMAT_INDEX);
  // RULE_01: unlock gates access
  assign fmt_open  = data_hit && fmt_sel && extension_unlock_i;
  assign fmt_wr    = io_wr_i && fmt_open;
  assign fmt_rd    = io_rd_i && fmt_open;
  assign idx_wr    = io_wr_i && index_hit;
  assign idx_rd    = io_rd_i && index_hit;

  // **********************************************************************
  // Index and format registers
  // **********************************************************************
  wire [7:0] next_format;

  // RULE_14: reserved bit masked
  assign next_format = fmt_wr ? (io_wdata_i & spfc_pkg::SPFC_FORMAT_WMASK)
                              : format;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      index  <= spfc_pkg::SPFC_INDEX_RESET;
      format <= spfc_pkg::SPFC_FORMAT_RESET;
    end else begin
      if (idx_wr) begin
        index <= io_wdata_i;
      end
      format <= next_format;
    end
  end

  // **********************************************************************
  // Read path
  // **********************************************************************
  wire [7:0] next_rdata;
  wire       next_rvalid;

  assign next_rdata  = fmt_rd ? format :
                       idx_rd ? index  : spfc_pkg::SPFC_READ_IDLE;
  assign next_rvalid = fmt_rd || idx_rd;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_o       <= spfc_pkg::SPFC_READ_IDLE;
      io_rdata_valid_o <= 1'b0;
    end else begin
      io_rdata_o       <= next_rdata;
      io_rdata_valid_o <= next_rvalid;
    end
  end

  // **********************************************************************
  // Format controls
  // **********************************************************************
  wire scan_allowed;
  wire next_single_scan;

  // RULE_05: panel type gate
  assign scan_allowed     = (panel_type_i == spfc_pkg::SPFC_PANEL_TYPE_MONO);
  // RULE_04: scan type select
  assign next_single_scan = scan_allowed &&
                            format[spfc_pkg::SPFC_BIT_SINGLE_SCN];

  // Bit 2 is stored and read back only; it steers nothing here
  // Controls follow the register one cycle late, like every output
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      alt_gray_o         <= 1'b0;
      mono_single_scan_o <= 1'b0;
      text_enh_o         <= 1'b0;
      dual_shift_clk_o   <= 1'b0;
      data_8bit_o        <= 1'b0;
    end else begin
      // RULE_03: grayscale scheme
      alt_gray_o         <= format[spfc_pkg::SPFC_BIT_ALT_GRAY];
      mono_single_scan_o <= next_single_scan;
      // RULE_06: text enhancement
      text_enh_o         <= format[spfc_pkg::SPFC_BIT_TEXT_ENH];
      // RULE_09: shift clock count
      dual_shift_clk_o   <= format[spfc_pkg::SPFC_BIT_DUAL_SCLK];
      // RULE_11: data width
      data_8bit_o        <= format[spfc_pkg::SPFC_BIT_DATA_8BIT];
    end
  end

  // **********************************************************************
  // Line clock pin
  // **********************************************************************
  logic                  short_pulse;
  spfc_pkg::spfc_lc_src_t lc_src;
  logic                  next_line_clock;

  spfc_pulse_gen #(
    .CNT_W (spfc_pkg::SPFC_LP_CNT_W),
    .WIDTH (spfc_pkg::SPFC_SHORT_LP_CYC)
  ) u_short_pulse (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n),
    .line_start_i (line_start_i),
    .pulse_o      (short_pulse)
  );

  // RULE_13: TFT sync routing
  // RULE_07: short pulse choice
  // RULE_08: timed pulse choice
  assign lc_src = tft_line_clk_sel_i ? spfc_pkg::SPFC_LC_HSYNC :
                  format[spfc_pkg::SPFC_BIT_SHORT_LP] ?
                  spfc_pkg::SPFC_LC_SHORT : spfc_pkg::SPFC_LC_TIMED;

  always_comb begin
    case (lc_src)
      spfc_pkg::SPFC_LC_HSYNC: next_line_clock = hsync_i;
      spfc_pkg::SPFC_LC_SHORT: next_line_clock = short_pulse;
      default:                 next_line_clock = timed_line_pulse_i;
    endcase
  end

  // One extra stage keeps the pin glitch free when the source changes
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      panel_line_clock_o <= 1'b0;
    end else begin
      panel_line_clock_o <= next_line_clock;
    end
  end

  // **********************************************************************
  // Checks
  // **********************************************************************
  chk_locked_write: assert property ( // RULE_01
    @(posedge mclk_i) disable iff (!rst_n)
    (io_wr_i && !extension_unlock_i) |=> (format == $past(format)))
    else $error("format changed while extensions locked");

  chk_locked_read: assert property ( // RULE_01
    @(posedge mclk_i) disable iff (!rst_n)
    (io_rd_i && data_hit && !extension_unlock_i) |=> !io_rdata_valid_o)
    else $error("format read answered while locked");

  chk_port_mode: assert property ( // RULE_02
    @(posedge mclk_i) disable iff (!rst_n)
    (io_wr_i && fmt_sel && extension_unlock_i &&
     (io_addr_i == (color_mode_i ? spfc_pkg::SPFC_MONO_DATA_PORT
                                 : spfc_pkg::SPFC_COLOR_DATA_PORT)))
    |=> (format == $past(format)))
    else $error("format written through port of other mode");

  chk_alt_gray: assert property ( // RULE_03
    @(posedge mclk_i) disable iff (!rst_n)
    fmt_wr ##1 1'b1 |=> (alt_gray_o ==
                         $past(io_wdata_i[spfc_pkg::SPFC_BIT_ALT_GRAY], 2)))
    else $error("alternate grayscale does not follow written bit");

  chk_scan_gate: assert property ( // RULE_05
    @(posedge mclk_i) disable iff (!rst_n)
    (panel_type_i != spfc_pkg::SPFC_PANEL_TYPE_MONO) |=>
    !mono_single_scan_o)
    else $error("scan selection acted for non-mono panel type");

  chk_scan_follow: assert property ( // RULE_04
    @(posedge mclk_i) disable iff (!rst_n)
    (scan_allowed && format[spfc_pkg::SPFC_BIT_SINGLE_SCN]) |=>
    mono_single_scan_o)
    else $error("single scan not selected");

  chk_text_enh: assert property ( // RULE_06
    @(posedge mclk_i) disable iff (!rst_n)
    $rose(text_enh_o) |-> $past(format[spfc_pkg::SPFC_BIT_TEXT_ENH]))
    else $error("text enhancement without format bit");

  chk_short_width: assert property ( // RULE_07
    @(posedge mclk_i) disable iff (!rst_n)
    (line_start_i && !tft_line_clk_sel_i &&
     format[spfc_pkg::SPFC_BIT_SHORT_LP]) ##1
    (!tft_line_clk_sel_i && format[spfc_pkg::SPFC_BIT_SHORT_LP] &&
     !line_start_i)[*5]
    |=> panel_line_clock_o ##1 !panel_line_clock_o)
    else $error("short line pulse width wrong");

  chk_timed_src: assert property ( // RULE_08
    @(posedge mclk_i) disable iff (!rst_n)
    (!tft_line_clk_sel_i && !format[spfc_pkg::SPFC_BIT_SHORT_LP]) |=>
    (panel_line_clock_o == $past(timed_line_pulse_i)))
    else $error("line pulse not taken from timing registers");

  chk_short_src: assert property ( // RULE_07
    @(posedge mclk_i) disable iff (!rst_n)
    (!tft_line_clk_sel_i && format[spfc_pkg::SPFC_BIT_SHORT_LP]) |=>
    (panel_line_clock_o == $past(short_pulse)))
    else $error("line pulse not taken from short pulse");

  chk_dual_sclk: assert property ( // RULE_09
    @(posedge mclk_i) disable iff (!rst_n)
    ##1 (dual_shift_clk_o == $past(format[spfc_pkg::SPFC_BIT_DUAL_SCLK])))
    else $error("shift clock select does not follow format");

  chk_data_width: assert property ( // RULE_11
    @(posedge mclk_i) disable iff (!rst_n)
    ##1 (data_8bit_o == $past(format[spfc_pkg::SPFC_BIT_DATA_8BIT])))
    else $error("data width select does not follow format");

  chk_hsync_route: assert property ( // RULE_13
    @(posedge mclk_i) disable iff (!rst_n)
    tft_line_clk_sel_i |=> (panel_line_clock_o == $past(hsync_i)))
    else $error("line clock pin does not carry hsync");

  chk_reserved_bit: assert property ( // RULE_14
    @(posedge mclk_i) disable iff (!rst_n)
    fmt_rd |=> (io_rdata_valid_o && !io_rdata_o[6]))
    else $error("reserved bit reads nonzero");

endmodule : spfc_top

// [spfc_panel_model.sv]
// Purpose: STN panel model, measures each line pulse on its line clock
// Assumes: Panel samples the line clock on rising edges of mclk_i
// Notes:   Reports pulse length when the line clock falls
`timescale 1ns/100ps
module spfc_panel_model (
  // Clock
  input  wire logic       mclk_i,
  // Panel pins
  input  wire logic       line_clock_i,
  // Measured line pulse
  output logic      [7:0] pulse_len_o,
  output logic            pulse_done_o
);
  logic [7:0] high_cnt = 8'h00;

  initial pulse_len_o = 8'h00;
  initial pulse_done_o = 1'b0;

  // Unknown pin counts as low, so no pulse is invented before reset
  always @(posedge mclk_i) begin
    pulse_done_o <= 1'b0;
    if (line_clock_i === 1'b1) begin
      high_cnt <= high_cnt + 8'h01;
    end else begin
      if (high_cnt != 8'h00) begin
        pulse_len_o  <= high_cnt;
        pulse_done_o <= 1'b1;
      end
      high_cnt <= 8'h00;
    end
  end
endmodule : spfc_panel_model

// [testbench.sv]
// Purpose: Self-checking bench for the STN panel format block
// Assumes: Inputs change on the falling edge of mclk_i
// Notes:   Read answers and line pulses are checked from queues
`timescale 1ns/100ps
module testbench;
  logic        mclk_i = 1'b0, resetn_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic        io_wr_i = 1'b0, io_rd_i = 1'b0;
  logic [7:0]  io_wdata_i = 8'h00, io_rdata_o, pl_len;
  logic        io_rdata_valid_o, pl_done;
  logic        color_mode_i = 1'b1, extension_unlock_i = 1'b1;
  logic [1:0]  panel_type_i = 2'h0;
  logic        tft_line_clk_sel_i = 1'b0, line_start_i = 1'b0;
  logic        timed_line_pulse_i = 1'b0, hsync_i = 1'b0;
  logic        alt_gray_o, mono_single_scan_o, text_enh_o;
  logic        dual_shift_clk_o, data_8bit_o, panel_line_clock_o;
  logic [7:0]  rd_q[$], pl_q[$], d;
  logic [4:0]  exp_ctl;
  int          err_count = 0, n_compared = 0, cyc = 0;

  spfc_top u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .io_rdata_valid_o(io_rdata_valid_o), .color_mode_i(color_mode_i),
    .extension_unlock_i(extension_unlock_i), .panel_type_i(panel_type_i),
    .tft_line_clk_sel_i(tft_line_clk_sel_i), .line_start_i(line_start_i),
    .timed_line_pulse_i(timed_line_pulse_i), .hsync_i(hsync_i),
    .alt_gray_o(alt_gray_o), .mono_single_scan_o(mono_single_scan_o),
    .text_enh_o(text_enh_o), .dual_shift_clk_o(dual_shift_clk_o),
    .data_8bit_o(data_8bit_o), .panel_line_clock_o(panel_line_clock_o));

  spfc_panel_model u_panel (.mclk_i(mclk_i),
    .line_clock_i(panel_line_clock_o), .pulse_len_o(pl_len),
    .pulse_done_o(pl_done));

  always #12.5 mclk_i = ~mclk_i;

  // ********************************************************************
  // Checking
  // ********************************************************************
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic close_out();
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Answers with no pending note count as mismatches
  always @(posedge mclk_i) begin
    #1;
    if (io_rdata_valid_o === 1'b1 && rd_q.size() == 0) begin
      err_count++;
      $display("unexpected %0t read answer with no note", $time);
    end else if (io_rdata_valid_o === 1'b1) begin
      cmp_val(io_rdata_o, rd_q.pop_front());
    end else if (resetn_i) begin
      cmp_val(io_rdata_o, 8'h00);
    end
    if (pl_done === 1'b1 && pl_q.size() == 0) begin
      err_count++;
      $display("unexpected %0t line pulse with no note", $time);
    end else if (pl_done === 1'b1) begin
      cmp_val(pl_len, pl_q.pop_front());
    end
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  // ********************************************************************
  // Stimulus
  // ********************************************************************
  function automatic logic [15:0] io_port(input logic c, input logic dp);
    if (c) return dp ? spfc_pkg::SPFC_COLOR_DATA_PORT
                     : spfc_pkg::SPFC_COLOR_INDEX_PORT;
    return dp ? spfc_pkg::SPFC_MONO_DATA_PORT : spfc_pkg::SPFC_MONO_INDEX_PORT;
  endfunction : io_port

  task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge mclk_i);
    io_addr_i = a;
    io_wdata_i = v;
    io_wr_i = 1'b1;
    @(negedge mclk_i);
    io_wr_i = 1'b0;
  endtask : io_wr

  task automatic io_rd(input logic [15:0] a, input logic ans,
                       input logic [7:0] e);
    if (ans) rd_q.push_back(e);
    @(negedge mclk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge mclk_i);
    io_rd_i = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask : io_rd

  task automatic set_fmt(input logic [7:0] v);
    io_wr(io_port(color_mode_i, 1'b0), spfc_pkg::SPFC_FORMAT_INDEX);
    io_wr(io_port(color_mode_i, 1'b1), v);
  endtask : set_fmt

  task automatic lines(input logic [7:0] ls, tm, hs, len);
    pl_q.push_back(len);
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk_i);
      line_start_i = ls[i];
      timed_line_pulse_i = tm[i];
      hsync_i = hs[i];
    end
    @(negedge mclk_i);
    line_start_i = 1'b0;
    timed_line_pulse_i = 1'b0;
    hsync_i = 1'b0;
    repeat (12) @(negedge mclk_i);
  endtask : lines

  initial begin
    void'($urandom(32'h9609));
    repeat (10) @(negedge mclk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    cmp_val({2'h0, alt_gray_o, mono_single_scan_o, text_enh_o,
             dual_shift_clk_o, data_8bit_o, panel_line_clock_o}, 8'h00);
    set_fmt(8'h00);
    io_rd(io_port(1'b1, 1'b1), 1'b1, spfc_pkg::SPFC_FORMAT_RESET);
    extension_unlock_i = 1'b0;
    io_wr(io_port(1'b1, 1'b1), 8'hFF);
    io_rd(io_port(1'b1, 1'b1), 1'b0, 8'h00);
    extension_unlock_i = 1'b1;
    io_wr(io_port(1'b1, 1'b0), 8'h09);
    io_wr(io_port(1'b1, 1'b1), 8'hFF);
    io_wr(io_port(1'b1, 1'b0), spfc_pkg::SPFC_FORMAT_INDEX);
    io_rd(io_port(1'b1, 1'b1), 1'b1, 8'h00);
    // other mode port refused, colour port answers
    io_wr(io_port(1'b0, 1'b1), 8'hFF);
    io_rd(io_port(1'b0, 1'b1), 1'b0, 8'h00);
    io_rd(io_port(1'b1, 1'b1), 1'b1, 8'h00);
    color_mode_i = 1'b0;
    set_fmt(8'hFF);
    io_rd(io_port(1'b0, 1'b1), 1'b1, 8'hBF);
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      // 8-bit data only with single shift clock
      if (d[1]) d[0] = 1'b0;
      color_mode_i = 1'($urandom);
      panel_type_i = 2'($urandom);
      set_fmt(d);
      io_rd(io_port(color_mode_i, 1'b1), 1'b1,
            d & spfc_pkg::SPFC_FORMAT_WMASK);
      exp_ctl = {d[7], d[5] & (panel_type_i == 2'h0), d[4], d[1], d[0]};
      cmp_val({alt_gray_o, mono_single_scan_o, text_enh_o, dual_shift_clk_o,
               data_8bit_o, 3'h0}, {exp_ctl, 3'h0});
    end
    set_fmt(8'h08);
    lines(8'h01, 8'h03, 8'h3F, 8'(spfc_pkg::SPFC_SHORT_LP_CYC));
    lines(8'h05, 8'h00, 8'h00, 8'(spfc_pkg::SPFC_SHORT_LP_CYC + 2));
    set_fmt(8'h00);
    lines(8'h01, 8'h07, 8'h00, 8'h03);
    tft_line_clk_sel_i = 1'b1;
    set_fmt(8'h08);
    lines(8'h01, 8'h00, 8'h0F, 8'h04);
    // Notes still waiting mean an answer never came
    if (rd_q.size() + pl_q.size() != 0) begin
      err_count++;
      $display("unexpected %0t notes left unanswered", $time);
    end
    close_out();
  end
endmodule : testbench
